// ===== common/atp_pkg.sv
// Constants shared by the timer clock-source and prescaler block
package atp_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam int          ADDR_W           = 4;
    localparam int          DATA_W           = 8;
    localparam logic [3:0]  ADDR_GEN_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_ASYNC_STAT  = 4'h1;
    localparam logic [3:0]  ADDR_CLK_SEL     = 4'h2;
    localparam logic [3:0]  ADDR_COUNT       = 4'h3;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int          BIT_SYNC_HOLD    = 7;
    localparam int          BIT_PSC_RESET    = 1;
    localparam int          BIT_ASYNC_SEL    = 3;
    localparam int          CLK_SEL_W        = 3;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic        RST_BIT          = 1'b0;
    localparam logic [7:0]  RST_BYTE         = 8'h00;

    // ********************************************************
    // Clock selection codes and prescaler taps
    // ********************************************************
    typedef enum logic [2:0] {
        SEL_STOP    = 3'h0,
        SEL_DIV1    = 3'h1,
        SEL_DIV8    = 3'h2,
        SEL_DIV32   = 3'h3,
        SEL_DIV64   = 3'h4,
        SEL_DIV128  = 3'h5,
        SEL_DIV256  = 3'h6,
        SEL_DIV1024 = 3'h7
    } atp_sel_t;

    localparam int          NUM_TAPS         = 6;
    // Low counter bits that must all be one for each tap
    localparam int          TAP_BITS [NUM_TAPS] = '{3, 5, 6, 7, 8, 10};
    localparam int          PSC_W            = 10;
    localparam int          TIMER_W          = 8;

endpackage : atp_pkg

// ===== common/atp_presc_if.sv
// Signals between the control logic and the prescaler
`timescale 1ns/1ns
interface atp_presc_if;
    logic                              srcTick;
    logic                              clrPresc;
    logic [atp_pkg::CLK_SEL_W-1:0]     clkSel;
    logic                              timerTick;

    modport ctl   (output srcTick, output clrPresc, output clkSel,
                   input timerTick);
    modport presc (input srcTick, input clrPresc, input clkSel,
                   output timerTick);
endinterface : atp_presc_if

// ===== src/atp_prescaler.sv
// Prescaler counter with fixed divide taps and clock selection
`timescale 1ns/1ns
module atp_prescaler #(
    parameter int PSC_W = atp_pkg::PSC_W
) (
    input  wire logic  ref_clk,
    input  wire logic  nrst,
    atp_presc_if.presc pif
);
    // ********************************************************
    // Checks
    // ********************************************************
    // Shorter counter cannot reach the longest tap
    if (PSC_W < atp_pkg::PSC_W) begin : g_bad_width
        $error("Prescaler too narrow for the longest tap");
    end

    logic [PSC_W-1:0]            cnt_ff;
    logic [atp_pkg::NUM_TAPS-1:0] tapHit;

    // ********************************************************
    // Counter
    // ********************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
        end else if (pif.clrPresc) begin
            cnt_ff <= '0;
        end else if (pif.srcTick) begin
            cnt_ff <= cnt_ff + {{(PSC_W-1){1'b0}}, 1'b1};
        end
    end

    // ********************************************************
    // Taps
    // ********************************************************
    generate
        for (genvar i = 0; i < atp_pkg::NUM_TAPS; i++) begin : g_tap
            localparam int W = atp_pkg::TAP_BITS[i];
            // Tap fires on the source tick that wraps its low bits
            assign tapHit[i] = pif.srcTick && !pif.clrPresc
                               && (&cnt_ff[W-1:0]);
        end
    endgenerate

    function automatic logic pickTap(
        input logic [2:0]                    sel,
        input logic                          src,
        input logic [atp_pkg::NUM_TAPS-1:0]  taps
    );
        logic r;
        r = 1'b0;
        case (sel)
            atp_pkg::SEL_STOP: r = 1'b0;
            atp_pkg::SEL_DIV1: r = src;
            default:           r = taps[sel - 3'h2];
        endcase
        return r;
    endfunction : pickTap

    assign pif.timerTick = pickTap(pif.clkSel, pif.srcTick, tapHit);

    // ********************************************************
    // Assertions
    // ********************************************************
    presc_clear_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        pif.clrPresc |=> (cnt_ff == '0))
        else $error("Prescaler not cleared by reset bit");

    div8_phase_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (pif.clkSel == atp_pkg::SEL_DIV8) && pif.timerTick
        |-> (cnt_ff[2:0] == 3'h7))
        else $error("Divide by 8 tap out of phase");

endmodule : atp_prescaler

// ===== src/atp_timer_top.sv
// Timer clock source select, prescaler control and 8-bit counter
//
// Function
// - Without async select, prescaler counts every system clock cycle.
// - With async select set, prescaler counts rising edges of oscillator pin.
// - Async select detaches both oscillator pins from the general port.
// - Prescaler offers taps dividing by 8, 32, 64, 128, 256, 1024.
// - Selection also offers the undivided source and a stop setting.
// - While the prescaler reset bit is one, the prescaler is reset.
// - Synchronous mode clears the reset bit right after it is written.
// - Async mode keeps the reset bit set until the prescaler reset happens.
// - Sync hold bit set stops hardware clearing of the reset bit.
// - Timer does not count while the stop setting is selected.
// - Async select bit lives in async status register; one selects oscillator.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module atp_timer_top #(
    parameter int TIMER_W = atp_pkg::TIMER_W
) (
    input  wire logic                       ref_clk,
    input  wire logic                       nrst,
    input  wire logic [atp_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [atp_pkg::DATA_W-1:0] regWrData,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic      [atp_pkg::DATA_W-1:0] regRdData,
    input  wire logic                       osc_in_pin,
    output logic                            oscPinsDetach,
    output logic      [TIMER_W-1:0]         timerCount,
    output logic                            timerTick
);
    // ********************************************************
    // Checks
    // ********************************************************
    // Count register is read back through the byte-wide bus
    if (TIMER_W != atp_pkg::DATA_W) begin : g_bad_width
        $error("Timer width must match the register width");
    end

    // ********************************************************
    // Declarations
    // ********************************************************
    logic                          syncHold_ff;
    logic                          pscReset_ff;
    logic                          asyncSel_ff;
    logic [atp_pkg::CLK_SEL_W-1:0] clkSel_ff;
    logic                          oscLast_ff;
    logic [TIMER_W-1:0]            count_ff;
    logic                          tick_ff;
    logic                          detach_ff;
    logic [atp_pkg::DATA_W-1:0]    rdData_ff;
    logic [atp_pkg::DATA_W-1:0]    nxt_rdData;
    logic                          oscRise;
    logic                          srcTick;
    logic                          wrCtrl;
    logic                          wrPscOne;
    logic                          pscClear;

    atp_presc_if pif ();

    // ********************************************************
    // Source clock
    // ********************************************************
    // Pin is taken as synchronous, so one register is enough
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oscLast_ff <= atp_pkg::RST_BIT;
        end else begin
            oscLast_ff <= osc_in_pin;
        end
    end

    assign oscRise = osc_in_pin && !oscLast_ff;
    // Oscillator edge or every cycle
    assign srcTick = asyncSel_ff ? oscRise : 1'b1;

    // ********************************************************
    // Register writes
    // ********************************************************
    assign wrCtrl   = regWr && (regAddr == atp_pkg::ADDR_GEN_CTRL);
    assign wrPscOne = wrCtrl && regWrData[atp_pkg::BIT_PSC_RESET];
    // Reset is seen by the prescaler only on a source tick
    assign pscClear = pscReset_ff && srcTick && !syncHold_ff;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            syncHold_ff <= atp_pkg::RST_BIT;
        end else if (wrCtrl) begin
            syncHold_ff <= regWrData[atp_pkg::BIT_SYNC_HOLD];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pscReset_ff <= atp_pkg::RST_BIT;
        end else if (wrPscOne) begin
            // A new write of one beats the hardware clear
            pscReset_ff <= 1'b1;
        end else if (wrCtrl && syncHold_ff) begin
            // Software drops the bit only while hold keeps it up
            pscReset_ff <= 1'b0;
        end else if (pscClear) begin
            pscReset_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            asyncSel_ff <= atp_pkg::RST_BIT;
        end else if (regWr && (regAddr == atp_pkg::ADDR_ASYNC_STAT)) begin
            asyncSel_ff <= regWrData[atp_pkg::BIT_ASYNC_SEL];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clkSel_ff <= atp_pkg::SEL_STOP;
        end else if (regWr && (regAddr == atp_pkg::ADDR_CLK_SEL)) begin
            clkSel_ff <= regWrData[atp_pkg::CLK_SEL_W-1:0];
        end
    end

    // ********************************************************
    // Prescaler
    // ********************************************************
    assign pif.srcTick  = srcTick;
    // Held while the bit is one, even under sync hold
    assign pif.clrPresc = pscReset_ff && srcTick;
    assign pif.clkSel   = clkSel_ff;

    atp_prescaler #(
        .PSC_W (atp_pkg::PSC_W)
    ) u_presc (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pif     (pif)
    );

    // ********************************************************
    // Timer counter and pin detach
    // ********************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= '0;
            tick_ff  <= atp_pkg::RST_BIT;
        end else begin
            tick_ff <= pif.timerTick;
            if (pif.timerTick) begin
                count_ff <= count_ff + {{(TIMER_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            detach_ff <= atp_pkg::RST_BIT;
        end else begin
            detach_ff <= asyncSel_ff;
        end
    end

    // ********************************************************
    // Register reads
    // ********************************************************
    always_comb begin
        nxt_rdData = atp_pkg::RST_BYTE;
        case (regAddr)
            atp_pkg::ADDR_GEN_CTRL: begin
                nxt_rdData[atp_pkg::BIT_SYNC_HOLD] = syncHold_ff;
                nxt_rdData[atp_pkg::BIT_PSC_RESET] = pscReset_ff;
            end
            atp_pkg::ADDR_ASYNC_STAT: begin
                nxt_rdData[atp_pkg::BIT_ASYNC_SEL] = asyncSel_ff;
            end
            atp_pkg::ADDR_CLK_SEL: begin
                nxt_rdData[atp_pkg::CLK_SEL_W-1:0] = clkSel_ff;
            end
            atp_pkg::ADDR_COUNT: begin
                nxt_rdData = count_ff;
            end
            default: begin
                nxt_rdData = atp_pkg::RST_BYTE;
            end
        endcase
    end

    // Data only valid the cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdData_ff <= atp_pkg::RST_BYTE;
        end else if (regRd) begin
            rdData_ff <= nxt_rdData;
        end else begin
            rdData_ff <= atp_pkg::RST_BYTE;
        end
    end

    assign regRdData     = rdData_ff;
    assign oscPinsDetach = detach_ff;
    assign timerCount    = count_ff;
    assign timerTick     = tick_ff;

    // ********************************************************
    // Assertions
    // ********************************************************
    sync_source_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !asyncSel_ff |-> srcTick)
        else $error("Sync source does not tick every cycle");

    async_source_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        asyncSel_ff && !(osc_in_pin && !$past(osc_in_pin)) |-> !srcTick)
        else $error("Async source ticked without oscillator edge");

    pin_detach_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        asyncSel_ff [*2] |-> oscPinsDetach)
        else $error("Oscillator pins not detached");

    undivided_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (clkSel_ff == atp_pkg::SEL_DIV1) && !asyncSel_ff
        |=> (timerCount == $past(timerCount) + 8'h01))
        else $error("Undivided clock did not advance timer");

    stop_hold_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (clkSel_ff == atp_pkg::SEL_STOP) |=> $stable(timerCount))
        else $error("Timer counted with clock stopped");

    sync_clear_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        wrPscOne && !syncHold_ff && !asyncSel_ff
        && !regWrData[atp_pkg::BIT_SYNC_HOLD]
        |=> pscReset_ff ##1 (!pscReset_ff || $past(regWr)))
        else $error("Reset bit not cleared right after write");

    async_keep_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        pscReset_ff && asyncSel_ff && !srcTick && !wrCtrl
        |=> pscReset_ff)
        else $error("Reset bit dropped before prescaler reset");

    hold_keep_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        pscReset_ff && syncHold_ff && !wrCtrl |=> pscReset_ff)
        else $error("Reset bit cleared under sync hold");

    hold_reset_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (pscReset_ff && syncHold_ff && !asyncSel_ff) [*2]
        |-> pif.clrPresc && !pif.timerTick
            || (clkSel_ff == atp_pkg::SEL_DIV1))
        else $error("Prescaler ran while held by sync hold");

    async_write_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        regWr && (regAddr == atp_pkg::ADDR_ASYNC_STAT)
        && regWrData[atp_pkg::BIT_ASYNC_SEL] |=> asyncSel_ff)
        else $error("Async select write not taken");

endmodule : atp_timer_top

// ===== verification/atp_osc_model.sv
// Crystal oscillator stand-in driving the timer oscillator input pin
`timescale 1ns/1ns
module atp_osc_model (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       oscEn,
    input  wire logic [7:0] halfCycles,
    output logic            oscOut
);
    // ********************************************************
    // Square wave, parked low while the crystal is stopped
    // ********************************************************
    logic [7:0] phaseCnt_ff;

    // Edges land just after ref_clk so the block samples a clean level
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phaseCnt_ff <= 8'h00;
            oscOut      <= 1'b0;
        end else if (!oscEn) begin
            phaseCnt_ff <= 8'h00;
            oscOut      <= 1'b0;
        end else if (phaseCnt_ff >= halfCycles - 8'h01) begin
            phaseCnt_ff <= 8'h00;
            oscOut      <= ~oscOut;
        end else begin
            phaseCnt_ff <= phaseCnt_ff + 8'h01;
        end
    end
endmodule : atp_osc_model

// ===== verification/test_async_timer_prescaler.sv
// Self-checking bench for the timer clock source and prescaler block
`timescale 1ns/1ns
module test_async_timer_prescaler;
    // ********************************************************
    // Stimulus and observed signals
    // ********************************************************
    logic       ref_clk;
    logic       nrst;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdData;
    logic       osc_in_pin;
    logic       oscPinsDetach;
    logic [7:0] timerCount;
    logic       timerTick;
    logic       oscEn;
    logic [7:0] halfCycles;
    logic [7:0] rdv;
    logic [7:0] cnt0;
    int         badCount;
    int         numChecks;
    int         seed;
    int         n;
    int         m;

    atp_timer_top dut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .osc_in_pin(osc_in_pin),
        .oscPinsDetach(oscPinsDetach), .timerCount(timerCount),
        .timerTick(timerTick));
    atp_osc_model osc (.ref_clk(ref_clk), .nrst(nrst), .oscEn(oscEn),
        .halfCycles(halfCycles), .oscOut(osc_in_pin));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ********************************************************
    // Compares, bus cycles and expectations
    // ********************************************************
    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check8

    task automatic check_int(input string what, input int exp, input int got);
        numChecks++;
        if (got != exp) begin
            badCount++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_int

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd

    // Cycles up to the next tick; lim + 1 when none came
    task automatic wait_tick(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end while (timerTick !== 1'b1 && cnt <= lim);
    endtask : wait_tick

    function automatic int exp_gap(input logic [2:0] s, input int per);
        int div [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
        return div[s] * per;
    endfunction : exp_gap

    // Second gap only: the first one straddles the selection change
    task automatic period_test(input logic [2:0] s, input int per);
        wr(atp_pkg::ADDR_CLK_SEL, {5'h00, s});
        wait_tick(4 * exp_gap(s, per) + 20, n);
        cnt0 = timerCount;
        wait_tick(4 * exp_gap(s, per) + 20, m);
        check_int("tick gap", exp_gap(s, per), m);
        check8("count step", cnt0 + 8'h01, timerCount);
    endtask : period_test

    task automatic stopTest;
        if (badCount == 0 && numChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stopTest

    initial begin
        repeat (40000) @(posedge ref_clk);
        badCount++;
        stopTest();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        seed = 32'h70cf;
        nrst = 1'b0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        oscEn = 1'b0;
        halfCycles = 8'h04;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            rd(a[3:0], rdv);
            check8("reset value", atp_pkg::RST_BYTE, rdv);
        end
        wr(4'hF, 8'($random(seed)));
        rd(4'hF, rdv);
        check8("unmapped read", 8'h00, rdv);
        cnt0 = timerCount;
        wait_tick(50, n);
        check_int("stopped ticks", 51, n);
        check8("stopped count", cnt0, timerCount);
        for (int s = 1; s < 8; s++) begin
            period_test(s[2:0], 1);
        end
        // Count register ignores writes
        wr(atp_pkg::ADDR_CLK_SEL, {5'h00, atp_pkg::SEL_STOP});
        repeat (3) @(posedge ref_clk);
        rd(atp_pkg::ADDR_COUNT, cnt0);
        wr(atp_pkg::ADDR_COUNT, ~cnt0);
        rd(atp_pkg::ADDR_COUNT, rdv);
        check8("count read only", cnt0, rdv);
        // Divider phase after reset is the same whatever the prior phase
        wr(atp_pkg::ADDR_CLK_SEL, {5'h00, atp_pkg::SEL_DIV8});
        for (int i = 0; i < 2; i++) begin
            repeat ($unsigned($random(seed)) % 8) @(posedge ref_clk);
            wr(atp_pkg::ADDR_GEN_CTRL, 8'h02);
            repeat (4) @(posedge ref_clk);
            wait_tick(20, n);
            if (i == 0) begin
                m = n;
            end else begin
                check_int("reset phase", m, n);
            end
        end
        rd(atp_pkg::ADDR_GEN_CTRL, rdv);
        check8("reset self clear", 8'h00, rdv);
        wr(atp_pkg::ADDR_GEN_CTRL, 8'h82);
        repeat (4) @(posedge ref_clk);
        wait_tick(40, n);
        check_int("held ticks", 41, n);
        rd(atp_pkg::ADDR_GEN_CTRL, rdv);
        check8("hold keeps bit", 8'h82, rdv);
        wr(atp_pkg::ADDR_GEN_CTRL, 8'h00);
        wait_tick(20, n);
        check_int("release tick", 1, int'(n <= 20));
        rd(atp_pkg::ADDR_GEN_CTRL, rdv);
        check8("release clears", 8'h00, rdv);
        // Oscillator mode with a random crystal rate
        halfCycles <= 8'h03 + 8'($unsigned($random(seed)) % 4);
        oscEn <= 1'b1;
        wr(atp_pkg::ADDR_ASYNC_STAT, 8'h08);
        rd(atp_pkg::ADDR_ASYNC_STAT, rdv);
        check8("async select", 8'h08, rdv);
        check8("pins detached", 8'h01, {7'h00, oscPinsDetach});
        period_test(atp_pkg::SEL_DIV1, 2 * int'(halfCycles));
        period_test(atp_pkg::SEL_DIV8, 2 * int'(halfCycles));
        @(posedge ref_clk);
        oscEn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        cnt0 = timerCount;
        wr(atp_pkg::ADDR_GEN_CTRL, 8'h02);
        repeat (20) @(posedge ref_clk);
        #1;
        check8("count frozen", cnt0, timerCount);
        rd(atp_pkg::ADDR_GEN_CTRL, rdv);
        check8("async reset pending", 8'h02, rdv);
        @(posedge ref_clk);
        oscEn <= 1'b1;
        repeat (4 * int'(halfCycles) + 4) @(posedge ref_clk);
        rd(atp_pkg::ADDR_GEN_CTRL, rdv);
        check8("async reset done", 8'h00, rdv);
        wr(atp_pkg::ADDR_ASYNC_STAT, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1;
        check8("pins attached", 8'h00, {7'h00, oscPinsDetach});
        period_test(atp_pkg::SEL_DIV8, 1);
        stopTest();
    end
endmodule : test_async_timer_prescaler
